// *** hdl/wdt_top.sv ***
// Watchdog timer with Avalon-MM register slave and interrupt logic
// Overview of operation
// - Reset pulse lasts 2^(n+1) clocks, n=3 bits
// - Hardcoded pulse length ignores software writes
// - Mode 0 resets; mode 1 interrupts first
// - Hardcoded response mode ignores software writes
// - Disabled: no counting, interrupts, or resets
// - Enable sticks until a system reset
// - Restart only on key 0x76 in byte0
// - Keyed restart also clears pending interrupt
// - Restart register always reads zero
// - Status bit 0 shows interrupt active
// - Reading clear register clears interrupt, no restart
// - Live count readable, resets to 0xffff
// - Timeout range bits 31:8 read zero; bits 7:4 repeat the range value
// - Version register holds ASCII digits plus asterisk
// - Type identification register at top offset
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "wdt_params.svh"
module wdt_top
  import wdt_pkg::*;
#(
  parameter logic PULSE_LENGTH_HARDCODED = 1'b0, // Locks pulse length field
  parameter logic RESPONSE_MODE_HARDCODED = 1'b0, // Locks response mode bit
  parameter logic [31:0] VERSION_CODE = 32'h3030_312a, // Arbitrary value, ASCII 001*
  parameter logic [31:0] TYPE_CODE = 32'h5744_0001 // Arbitrary value
)(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] avs_address, // Byte address
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic wdt_irq_q, // Watchdog interrupt line
  output logic sys_rst_q, // System reset request, active high
  output logic irq_q // Summary of masked sticky events
);
  // Control state
  logic en_q; // Enable, sticky
  logic rmod_q; // Response mode
  logic [2:0] rpl_q; // Reset pulse length code
  logic [3:0] top_q; // Timeout range selector
  logic [`WDT_CNT_W-1:0] cnt_q; // Live down counter
  logic wdt_int_q; // Internal watchdog interrupt
  logic [`WDT_EVT_W-1:0] evt_q; // Sticky event status
  logic [`WDT_EVT_W-1:0] mask_q; // Event enable mask
  // Bus slave state
  wdt_bus_state_t bus_q;
  logic [31:0] rdata_q;
  logic wait_q;
  // Strobes
  logic wr_acc; // Write accepted this cycle
  logic rd_acc; // Read accepted this cycle
  logic timeout; // Counter hit zero while enabled
  logic kick; // Valid keyed restart
  logic eoi; // Interrupt clear read
  logic fire; // Start of a system reset
  logic rp_sys_rst; // Stretcher output
  logic rp_done; // Pulse finished: reinit registers
  logic [31:0] wmask; // Byte enables as bit mask

  // Byte lanes to bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  // Reload value for a range selector: 2^(16+top)-1 clipped to counter width
  function automatic logic [`WDT_CNT_W-1:0] reload_val(input logic [3:0] top);
    reload_val = {`WDT_CNT_W{1'b1}} >> ((4'hf - top) & 4'h0);
  endfunction : reload_val

  // Word offset match helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a[7:2] == ofs[7:2]);
  endfunction : hit

  assign wmask = lane_mask(avs_byteenable);
  assign wr_acc = (bus_q == WDT_BUS_ACK) && avs_write;
  assign rd_acc = (bus_q == WDT_BUS_ACK) && avs_read;
  assign timeout = en_q && (cnt_q == '0) && !sys_rst_q;
  assign kick = wr_acc && hit(avs_address, `WDT_OFS_RESTART) && avs_byteenable[0]
                && (avs_writedata[7:0] == `WDT_RESTART_KEY);
  assign eoi = rd_acc && hit(avs_address, `WDT_OFS_CLEAR);
  // Mode 0 resets at once; mode 1 resets on second timeout with irq pending
  assign fire = timeout && (!rmod_q || wdt_int_q);

  // Reset pulse generator
  wdt_reset_pulse u_pulse (
    .mclk(mclk),
    .rst_n(rst_n),
    .fire(fire),
    .rpl(rpl_q),
    .sys_rst_q(rp_sys_rst),
    .done_q(rp_done)
  );

  // Bus handshake: one wait cycle, answer in the next, then one idle cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_q <= WDT_BUS_IDLE;
      wait_q <= 1'b1;
    end else begin
      case (bus_q)
        WDT_BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_q <= WDT_BUS_ACK;
            wait_q <= 1'b0;
          end
        end
        WDT_BUS_ACK: begin
          bus_q <= WDT_BUS_DONE;
          wait_q <= 1'b1;
        end
        WDT_BUS_DONE: begin
          bus_q <= WDT_BUS_IDLE;
        end
        default: begin
          bus_q <= WDT_BUS_IDLE;
          wait_q <= 1'b1;
        end
      endcase
    end
  end

  // Read data is loaded so it stands with waitrequest low
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (bus_q == WDT_BUS_IDLE && avs_read) begin
      case ({avs_address[7:2], 2'b00})
        `WDT_OFS_CONTROL: rdata_q <= {27'h0, rpl_q, rmod_q, en_q};
        `WDT_OFS_TIMEOUT: rdata_q <= {24'h0, top_q, top_q};
        `WDT_OFS_COUNT: rdata_q <= {16'h0, cnt_q};
        `WDT_OFS_RESTART: rdata_q <= 32'h0000_0000;
        `WDT_OFS_STATUS: rdata_q <= {31'h0, wdt_int_q};
        `WDT_OFS_CLEAR: rdata_q <= 32'h0000_0000;
        `WDT_OFS_IRQ_MASK: rdata_q <= {30'h0, mask_q};
        `WDT_OFS_IRQ_EVENT: rdata_q <= {30'h0, evt_q};
        `WDT_OFS_PARAM5: rdata_q <= 32'h0000_0000;
        `WDT_OFS_PARAM4: rdata_q <= 32'h0000_0000;
        `WDT_OFS_PARAM3: rdata_q <= 32'h0000_0000;
        `WDT_OFS_PARAM2: rdata_q <= `WDT_VAL_PARAM2;
        `WDT_OFS_PARAM1: rdata_q <= 32'h0000_0000;
        `WDT_OFS_VERSION: rdata_q <= VERSION_CODE;
        `WDT_OFS_TYPE: rdata_q <= TYPE_CODE;
        // Unmapped offsets read zero
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Control register; a finished reset pulse restores reset values
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= 1'b0;
      rmod_q <= `WDT_RST_RMOD;
      rpl_q <= `WDT_RST_RPL;
      top_q <= `WDT_RST_TOP;
    end else if (rp_done) begin
      en_q <= 1'b0;
      rmod_q <= `WDT_RST_RMOD;
      rpl_q <= `WDT_RST_RPL;
      top_q <= `WDT_RST_TOP;
    end else if (wr_acc && hit(avs_address, `WDT_OFS_CONTROL) && avs_byteenable[0]) begin
      // Enable only ever sets from software
      if (avs_writedata[`WDT_BIT_EN]) begin
        en_q <= 1'b1;
      end
      if (!RESPONSE_MODE_HARDCODED) begin
        rmod_q <= avs_writedata[`WDT_BIT_RMOD];
      end
      if (!PULSE_LENGTH_HARDCODED) begin
        rpl_q <= avs_writedata[`WDT_RPL_MSB:`WDT_RPL_LSB];
      end
    end else if (wr_acc && hit(avs_address, `WDT_OFS_TIMEOUT) && avs_byteenable[0]) begin
      top_q <= avs_writedata[3:0];
    end
  end

  // Down counter: stalls when disabled, reloads on zero or restart
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= `WDT_RST_COUNT;
    end else if (rp_done) begin
      cnt_q <= `WDT_RST_COUNT;
    end else if (kick) begin
      cnt_q <= reload_val(top_q);
    end else if (timeout) begin
      cnt_q <= reload_val(top_q);
    end else if (en_q && !sys_rst_q) begin
      cnt_q <= cnt_q - `WDT_CNT_W'(1);
    end
  end

  // Watchdog interrupt; a new timeout wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_int_q <= 1'b0;
    end else if (rp_done) begin
      wdt_int_q <= 1'b0;
    end else if (timeout && rmod_q) begin
      wdt_int_q <= 1'b1;
    end else if (kick || eoi) begin
      wdt_int_q <= 1'b0;
    end
  end

  // Sticky event bits, write one to clear, set wins over clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      evt_q <= '0;
      mask_q <= '0;
    end else begin
      if (wr_acc && hit(avs_address, `WDT_OFS_IRQ_MASK)) begin
        mask_q <= avs_writedata[`WDT_EVT_W-1:0] & wmask[`WDT_EVT_W-1:0];
      end
      evt_q <= (evt_q & ~((wr_acc && hit(avs_address, `WDT_OFS_IRQ_EVENT))
                ? (avs_writedata[`WDT_EVT_W-1:0] & wmask[`WDT_EVT_W-1:0])
                : {`WDT_EVT_W{1'b0}}))
               | {fire, timeout};
    end
  end

  // Registered outputs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_irq_q <= 1'b0;
      sys_rst_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      wdt_irq_q <= wdt_int_q;
      sys_rst_q <= rp_sys_rst;
      irq_q <= |(evt_q & mask_q);
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
endmodule : wdt_top

// *** hdl/wdt_params.svh ***
// Register offsets, field positions, reset values and timing constants of the watchdog
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH
`define WDT_ADDR_W 8
`define WDT_OFS_CONTROL 8'h00
`define WDT_OFS_TIMEOUT 8'h04
`define WDT_OFS_COUNT 8'h08
`define WDT_OFS_RESTART 8'h0c
`define WDT_OFS_STATUS 8'h10
`define WDT_OFS_CLEAR 8'h14
`define WDT_OFS_IRQ_MASK 8'h18
`define WDT_OFS_IRQ_EVENT 8'h1c
`define WDT_OFS_PARAM5 8'he4
`define WDT_OFS_PARAM4 8'he8
`define WDT_OFS_PARAM3 8'hec
`define WDT_OFS_PARAM2 8'hf0
`define WDT_OFS_PARAM1 8'hf4
`define WDT_OFS_VERSION 8'hf8
`define WDT_OFS_TYPE 8'hfc
`define WDT_BIT_EN 0
`define WDT_BIT_RMOD 1
`define WDT_RPL_LSB 2
`define WDT_RPL_MSB 4
`define WDT_RST_CONTROL 32'h0000_000a
`define WDT_RST_RPL 3'h2
`define WDT_RST_RMOD 1'b1
`define WDT_RST_TOP 4'h0
`define WDT_RST_COUNT 16'hffff
`define WDT_VAL_PARAM2 32'h0000_ffff
`define WDT_RESTART_KEY 8'h76
`define WDT_CNT_W 16
`define WDT_EVT_W 2
`define WDT_EVT_TIMEOUT 0
`define WDT_EVT_SYSRST 1
`endif

// *** hdl/wdt_pkg.sv ***
// Types shared by the watchdog design files
package wdt_pkg;
  // Bus slave phases, one-hot
  typedef enum logic [2:0] {
    WDT_BUS_IDLE = 3'b001,
    WDT_BUS_ACK = 3'b010,
    WDT_BUS_DONE = 3'b100
  } wdt_bus_state_t;
  // Reset pulse phases, one-hot
  typedef enum logic [1:0] {
    WDT_RP_IDLE = 2'b01,
    WDT_RP_HOLD = 2'b10
  } wdt_rp_state_t;
endpackage : wdt_pkg

// *** hdl/wdt_reset_pulse.sv ***
// Reset pulse stretcher for the watchdog system reset
`timescale 1ns/1ns
`include "wdt_params.svh"
module wdt_reset_pulse
  import wdt_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic fire,
  input wire logic [2:0] rpl,
  output logic sys_rst_q,
  output logic done_q
);
  wdt_rp_state_t state_q; // Pulse phase
  logic [8:0] left_q; // Cycles of pulse still to run

  // Pulse length: code n gives 2^(n+1) cycles
  function automatic logic [8:0] pulse_len(input logic [2:0] code);
    pulse_len = 9'h002 << code;
  endfunction : pulse_len

  // Hold reset for the chosen count, then flag completion once
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= WDT_RP_IDLE;
      left_q <= 9'h000;
      sys_rst_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        WDT_RP_IDLE: begin
          if (fire) begin
            state_q <= WDT_RP_HOLD;
            left_q <= pulse_len(rpl) - 9'h001;
            sys_rst_q <= 1'b1;
          end
        end
        WDT_RP_HOLD: begin
          if (left_q == 9'h000) begin
            state_q <= WDT_RP_IDLE;
            sys_rst_q <= 1'b0;
            done_q <= 1'b1;
          end else begin
            left_q <= left_q - 9'h001;
          end
        end
        default: begin
          state_q <= WDT_RP_IDLE;
          sys_rst_q <= 1'b0;
        end
      endcase
    end
  end
endmodule : wdt_reset_pulse

// *** test/wdt_chk_asserts.sv ***
// Concurrent checks on the watchdog top ports
`timescale 1ns/1ns
`include "wdt_params.svh"
module wdt_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic wdt_irq_q,
  input wire logic sys_rst_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Accepted read or write this cycle
  wire rd_ok = avs_read && !avs_waitrequest;
  wire wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire key_ok = wr_ok && avs_address == `WDT_OFS_RESTART;
  logic [9:0] hi_q; // Cycles the reset request has stood
  // Pulse length counter; wide enough that a stuck pulse trips the limit before it wraps
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hi_q <= 10'h000;
    end else begin
      hi_q <= sys_rst_q ? hi_q + 10'h001 : 10'h000;
    end
  end
  property p_crr_zero;
    rd_ok && avs_address == `WDT_OFS_RESTART |-> avs_readdata == 32'h0000_0000;
  endproperty
  a_crr_zero: assert property (p_crr_zero) else $error("restart read not zero");
  property p_torr_hi;
    rd_ok && avs_address == `WDT_OFS_TIMEOUT |-> avs_readdata[31:8] == 24'h00_0000;
  endproperty
  a_torr_hi: assert property (p_torr_hi) else $error("timeout upper bits set");
  property p_eoi_clr;
    rd_ok && avs_address == `WDT_OFS_CLEAR |-> ##[1:3] !wdt_irq_q;
  endproperty
  a_eoi_clr: assert property (p_eoi_clr) else $error("clear read kept irq");
  property p_key_clr;
    key_ok && avs_writedata[7:0] == `WDT_RESTART_KEY |-> ##[1:3] !wdt_irq_q;
  endproperty
  a_key_clr: assert property (p_key_clr) else $error("key kept irq");
  property p_bad_key;
    key_ok && avs_writedata[7:0] != `WDT_RESTART_KEY && wdt_irq_q |=> wdt_irq_q[*2];
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("wrong key cleared irq");
  property p_pulse_min;
    $rose(sys_rst_q) |-> sys_rst_q[*2];
  endproperty
  a_pulse_min: assert property (p_pulse_min) else $error("reset pulse short");
  property p_pulse_max;
    hi_q <= 10'h101;
  endproperty
  a_pulse_max: assert property (p_pulse_max) else $error("reset pulse long");
  property p_irq_hold;
    wdt_irq_q && avs_waitrequest && $past(avs_waitrequest) && !sys_rst_q
      && !$past(sys_rst_q) && !$past(sys_rst_q, 2) |=> wdt_irq_q;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped alone");
endmodule : wdt_chk
bind wdt_top wdt_chk wdt_chk_inst (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .wdt_irq_q(wdt_irq_q), .sys_rst_q(sys_rst_q));

// *** test/tb.sv ***
// Self-checking bench for the watchdog top
`timescale 1ns/1ns
`include "wdt_params.svh"
module tb;
  localparam logic [31:0] TYPE_VAL = 32'h5744_0001; // Arbitrary value
  logic mclk, rst_n, avs_read, avs_write, avs_waitrequest, wdt_irq_q, sys_rst_q, irq_q;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable;
  int n_fail = 0;
  int n_tests = 0;
  wdt_top #(.TYPE_CODE(TYPE_VAL)) wdt_top_inst (.mclk(mclk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .wdt_irq_q(wdt_irq_q), .sys_rst_q(sys_rst_q), .irq_q(irq_q));
  // 50 MHz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // One Avalon access; idle edge after it since the slave rests a cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge mclk);
      n++;
    end
    if (n == 50) n_fail++;
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask : bus
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk
  task automatic t_reset;
    rdchk(`WDT_OFS_CONTROL, `WDT_RST_CONTROL); // Control reset
    rdchk(`WDT_OFS_COUNT, 32'h0000_ffff); // Count reset
    rdchk(`WDT_OFS_COUNT, 32'h0000_ffff); // Frozen while off
    rdchk(`WDT_OFS_STATUS, 32'h0); // Idle status
    rdchk(`WDT_OFS_CLEAR, 32'h0); // Clear reads zero
    rdchk(`WDT_OFS_PARAM2, `WDT_VAL_PARAM2); // Build value
    rdchk(`WDT_OFS_PARAM5, 32'h0); // Build value
    rdchk(`WDT_OFS_TYPE, TYPE_VAL); // Type code
    rdchk(8'h80, 32'h0); // Unmapped
    bus(1'b0, `WDT_OFS_VERSION, 32'h0);
    chk({24'h0, rd[7:0]}, 32'h2a); // Trailing asterisk
    for (int i = 1; i < 4; i++) begin
      chk({31'h0, rd[8*i+:8] inside {[8'h30:8'h39]}}, 32'h1); // ASCII digit
    end
  endtask : t_reset
  task automatic t_regs;
    bus(1'b1, `WDT_OFS_TIMEOUT, 32'hffff_ff05);
    rdchk(`WDT_OFS_TIMEOUT, 32'h0000_0055); // Upper bits zero
    bus(1'b1, `WDT_OFS_RESTART, 32'h0000_0076);
    rdchk(`WDT_OFS_RESTART, 32'h0); // Restart reads zero
  endtask : t_regs
  task automatic t_enable;
    logic [31:0] c1;
    bus(1'b1, `WDT_OFS_CONTROL, 32'h0000_0003);
    rdchk(`WDT_OFS_CONTROL, 32'h0000_0003); // Mode 1, short pulse
    c1 = rd;
    bus(1'b1, `WDT_OFS_CONTROL, 32'h0000_0002);
    rdchk(`WDT_OFS_CONTROL, 32'h0000_0003); // Enable sticks
    bus(1'b0, `WDT_OFS_COUNT, 32'h0);
    c1 = rd;
    bus(1'b0, `WDT_OFS_COUNT, 32'h0);
    chk({31'h0, rd < c1}, 32'h1); // Counting down
    bus(1'b1, `WDT_OFS_IRQ_MASK, 32'h1);
  endtask : t_enable
  // Mode 1 timeout: interrupt, no reset; then mask, keys and clears
  task automatic t_timeout;
    logic [31:0] c0;
    int n;
    n = 0;
    while (wdt_irq_q !== 1'b1 && n < 70000) begin
      @(posedge mclk);
      n++;
    end
    chk({31'h0, wdt_irq_q}, 32'h1); // Timeout raises irq
    chk({31'h0, sys_rst_q}, 32'h0); // No reset on first
    rdchk(`WDT_OFS_STATUS, 32'h1); // Status active
    rdchk(`WDT_OFS_IRQ_EVENT, 32'h1); // Timeout event latched
    chk({31'h0, irq_q}, 32'h1); // Unmasked event
    bus(1'b1, `WDT_OFS_IRQ_MASK, 32'h0);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq_q}, 32'h0); // Masked event
    bus(1'b1, `WDT_OFS_RESTART, 32'h0000_0075);
    repeat (2) @(posedge mclk);
    chk({31'h0, wdt_irq_q}, 32'h1); // Wrong key ignored
    bus(1'b1, `WDT_OFS_IRQ_MASK, 32'h1);
    bus(1'b1, `WDT_OFS_IRQ_EVENT, 32'h1);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq_q}, 32'h0); // Event write-one clear
    bus(1'b1, `WDT_OFS_RESTART, 32'h0000_0076);
    repeat (2) @(posedge mclk);
    chk({31'h0, wdt_irq_q}, 32'h0); // Key clears irq
    bus(1'b0, `WDT_OFS_COUNT, 32'h0);
    chk({31'h0, rd > 32'h0000_ff00}, 32'h1); // Key reloads count
    // Clear read must leave the running count alone, so it keeps falling
    c0 = rd;
    rdchk(`WDT_OFS_CLEAR, 32'h0); // Clear reads zero
    bus(1'b0, `WDT_OFS_COUNT, 32'h0);
    chk({31'h0, rd < c0}, 32'h1); // No restart on clear
  endtask : t_timeout
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  // Watchdog against a hang; the run needs about 66000 cycles
  initial begin
    repeat (80000) @(posedge mclk);
    n_fail++;
    summarize();
  end
  initial begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_regs();
    t_enable();
    t_timeout();
    summarize();
  end
endmodule : tb
